// *** core/sevt_top.sv ***
`timescale 1ns/1ps
`include "sevt_map.svh"

// Overview of operation
// - mask bits 5,6 low enable slot interrupts
// - interrupt raised when slot registers load
// - status bits 5,6 pending, write-one clears
// - freeze bits block slot register loads
// - timing from 32 kHz and 32 MHz
// - six-bit slow clock trim output
// - enabled: count fast cycles over two slow
// - clearing enable resets ratio measurement
// - eight-bit fast clock trim output
// - per pin open-drain and polarity control
// - five-bit selectors for both aux pins
// - code 0x01 gives combined interrupt
// - code 0x02 gives sample window
// - codes 0x05-0x07 copy LED pulses
// - codes 0x0C-0x0E give data cycle
// - code 0x0F half sample rate square
// - codes 0x10, 0x11 constant low/high
// - code 0x13 copies slow oscillator
// - three-bit pin zero interrupt configuration
// - slot registers load separately, each at its own slot end
// - mode write 2 starts normal operation
module sevt_top
	import sevt_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// serial register port
	input  wire logic              spi_sclk,
	input  wire logic              spi_cs_n,
	input  wire logic              spi_mosi,
	output logic                   spi_miso_o,
	output logic                   spi_miso_oe,
	// slot timing from the sequencer
	input  wire sevt_slot_evt_type slot_a_evt,
	input  wire sevt_slot_evt_type slot_b_evt,
	input  wire logic              osc_slow,
	input  wire logic              fast_tick,
	// towards data registers and oscillators
	output logic                   slot_a_load,
	output logic                   slot_b_load,
	output logic                   sample_clock_on,
	output logic [5:0]             sample_clock_trim,
	output logic [7:0]             fast_clock_trim,
	output logic [1:0]             op_mode,
	// aux pins
	output logic [1:0]             aux_pin_o,
	output logic [1:0]             aux_pin_oe
);

	// ****************************************
	// serial port, link clock domain
	// ****************************************
	logic [5:0]        bit_cnt_q;
	logic [15:0]       rx_q;
	logic [7:0]        cmd_q;
	logic [15:0]       tx_q;
	logic              miso_q;
	logic              wr_tog_q;
	logic              rd_tog_q;
	sevt_reg_word_type wr_word_q;
	logic [6:0]        rd_addr_q;
	logic [15:0]       rd_data_q;

	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			bit_cnt_q <= 6'h00;
			rx_q      <= 16'h0000;
			cmd_q     <= 8'h00;
		end else begin
			rx_q <= {rx_q[14:0], spi_mosi};
			if (bit_cnt_q != `SEVT_BIT_CNT_MAX) begin
				bit_cnt_q <= bit_cnt_q + 6'h01;
			end
			if (bit_cnt_q == `SEVT_CMD_LAST_BIT) begin
				cmd_q <= {rx_q[6:0], spi_mosi};
			end
		end
	end

	always_ff @(posedge spi_sclk or posedge rst) begin
		if (rst) begin
			wr_tog_q  <= 1'b0;
			rd_tog_q  <= 1'b0;
			wr_word_q <= '0;
			rd_addr_q <= 7'h00;
		end else if (!spi_cs_n) begin
			if (bit_cnt_q == `SEVT_CMD_LAST_BIT && !spi_mosi) begin
				rd_addr_q <= rx_q[6:0];
				rd_tog_q  <= ~rd_tog_q;
			end
			if (bit_cnt_q == `SEVT_WR_LAST_BIT && cmd_q[0]) begin
				wr_word_q <= '{addr: cmd_q[7:1], data: {rx_q[14:0], spi_mosi}};
				wr_tog_q  <= ~wr_tog_q;
			end
		end
	end

	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			tx_q <= 16'h0000;
		end else if (bit_cnt_q == `SEVT_RD_LOAD_BIT && !cmd_q[0]) begin
			tx_q <= rd_data_q;
		end else begin
			tx_q <= {tx_q[14:0], 1'b0};
		end
	end

	always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			miso_q <= 1'b0;
		end else begin
			miso_q <= tx_q[15];
		end
	end

	assign spi_miso_o  = miso_q;
	assign spi_miso_oe = ~spi_cs_n;

	// ****************************************
	// crossings into the reference domain
	// ****************************************
	logic [2:0] wr_sync_q;
	logic [2:0] rd_sync_q;
	logic [2:0] osc_sync_q;
	logic       wr_evt;
	logic       rd_evt;
	logic       osc_rise;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_sync_q  <= 3'h0;
			rd_sync_q  <= 3'h0;
			osc_sync_q <= 3'h0;
		end else begin
			wr_sync_q  <= {wr_sync_q[1:0], wr_tog_q};
			rd_sync_q  <= {rd_sync_q[1:0], rd_tog_q};
			osc_sync_q <= {osc_sync_q[1:0], osc_slow};
		end
	end

	assign wr_evt   = wr_sync_q[2] ^ wr_sync_q[1];
	assign rd_evt   = rd_sync_q[2] ^ rd_sync_q[1];
	assign osc_rise = osc_sync_q[1] & ~osc_sync_q[2];

	function automatic logic wr_hit(input logic [6:0] ofs);
		return wr_evt && wr_word_q.addr == ofs;
	endfunction

	// ****************************************
	// control registers
	// ****************************************
	logic [15:0] mask_q;
	logic [15:0] pin_cfg_q;
	logic [15:0] pin_sel_q;
	logic [15:0] slow_ctl_q;
	logic [15:0] fast_trim_q;
	logic        ratio_en_q;
	logic [2:0]  hold_q;
	logic [1:0]  mode_q;
	logic        enter_normal;

	assign enter_normal = wr_hit(`SEVT_OFS_MODE) && wr_word_q.data[1:0] == `SEVT_MODE_NORMAL
		&& mode_q != `SEVT_MODE_NORMAL;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_q      <= `SEVT_RST_MASK;
			pin_cfg_q   <= `SEVT_RST_PIN_CFG;
			pin_sel_q   <= `SEVT_RST_PIN_SEL;
			slow_ctl_q  <= `SEVT_RST_SLOW_CTL;
			fast_trim_q <= `SEVT_RST_FAST_TRIM;
			ratio_en_q  <= 1'b0;
			hold_q      <= 3'h0;
			mode_q      <= 2'h0;
		end else if (wr_evt) begin
			unique case (wr_word_q.addr)
				`SEVT_OFS_MASK:      mask_q      <= wr_word_q.data;
				`SEVT_OFS_PIN_CFG:   pin_cfg_q   <= wr_word_q.data & `SEVT_PIN_CFG_MASK;
				`SEVT_OFS_PIN_SEL:   pin_sel_q   <= wr_word_q.data & `SEVT_PIN_SEL_MASK;
				`SEVT_OFS_SLOW_CTL:  slow_ctl_q  <= wr_word_q.data;
				`SEVT_OFS_FAST_TRIM: fast_trim_q <= wr_word_q.data;
				`SEVT_OFS_CAL_CTL:   ratio_en_q  <= wr_word_q.data[`SEVT_BIT_RATIO_EN];
				`SEVT_OFS_HOLD:      hold_q      <= wr_word_q.data[2:0];
				`SEVT_OFS_MODE:      mode_q      <= wr_word_q.data[1:0];
				default:             ;
			endcase
		end
	end

	assign sample_clock_on   = slow_ctl_q[`SEVT_BIT_CLK_ON];
	assign sample_clock_trim = slow_ctl_q[5:0];
	assign fast_clock_trim   = fast_trim_q[7:0];
	assign op_mode           = mode_q;

	// ****************************************
	// slot loads and sticky status
	// ****************************************
	logic [1:0] status_q;
	logic [1:0] status_set;
	logic [1:0] status_clr;
	logic       irq;

	assign slot_a_load = slot_a_evt.done & slot_a_evt.en & ~hold_q[`SEVT_BIT_FREEZE_A];
	assign slot_b_load = slot_b_evt.done & slot_b_evt.en & ~hold_q[`SEVT_BIT_FREEZE_B];
	assign status_set  = {slot_b_load, slot_a_load};
	assign status_clr  = wr_hit(`SEVT_OFS_STATUS) ?
		wr_word_q.data[`SEVT_BIT_SLOT_B:`SEVT_BIT_SLOT_A] : 2'h0;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_q <= 2'h0;
		end else begin
			status_q <= (status_q & ~status_clr) | status_set;
		end
	end

	assign irq = |(status_q & ~mask_q[`SEVT_BIT_SLOT_B:`SEVT_BIT_SLOT_A]);

	// ****************************************
	// fast clock ratio measurement
	// ****************************************
	sevt_ratio_state_type rs_q;
	logic [11:0]          ratio_cnt_q;
	logic [11:0]          ratio_res_q;
	logic                 edge_seen_q;
	logic [11:0]          cnt_next;

	assign cnt_next = (ratio_cnt_q == `SEVT_RATIO_MAX) ? ratio_cnt_q : ratio_cnt_q + {11'h000, fast_tick};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rs_q        <= SEVT_RS_IDLE;
			ratio_cnt_q <= 12'h000;
			ratio_res_q <= 12'h000;
			edge_seen_q <= 1'b0;
		end else if (!ratio_en_q) begin
			rs_q        <= SEVT_RS_IDLE;
			ratio_cnt_q <= 12'h000;
			ratio_res_q <= 12'h000;
			edge_seen_q <= 1'b0;
		end else begin
			unique case (rs_q)
				SEVT_RS_IDLE: begin
					rs_q <= SEVT_RS_ARM;
				end
				SEVT_RS_ARM: begin
					if (osc_rise) begin
						rs_q        <= SEVT_RS_COUNT;
						ratio_cnt_q <= 12'h000;
						edge_seen_q <= 1'b0;
					end
				end
				SEVT_RS_COUNT: begin
					ratio_cnt_q <= cnt_next;
					if (osc_rise) begin
						edge_seen_q <= 1'b1;
						if (edge_seen_q) begin
							rs_q        <= SEVT_RS_DONE;
							ratio_res_q <= cnt_next;
						end
					end
				end
				SEVT_RS_DONE: begin
					rs_q <= SEVT_RS_DONE;
				end
				default: begin
					rs_q <= SEVT_RS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// timing signals
	// ****************************************
	logic window_q;
	logic dcyc_a_q;
	logic dcyc_b_q;
	logic half_q;
	logic sample_start;
	logic sample_end;

	assign sample_start = slot_a_evt.en ? slot_a_evt.start : slot_b_evt.start;
	assign sample_end   = slot_b_evt.en ? slot_b_evt.done : slot_a_evt.done;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			window_q <= 1'b0;
		end else if (sample_start) begin
			window_q <= 1'b1;
		end else if (sample_end) begin
			window_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dcyc_a_q <= 1'b0;
			dcyc_b_q <= 1'b0;
		end else if (sample_start) begin
			dcyc_a_q <= 1'b0;
			dcyc_b_q <= 1'b0;
		end else begin
			dcyc_a_q <= dcyc_a_q | slot_a_load;
			dcyc_b_q <= dcyc_b_q | slot_b_load;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			half_q <= 1'b0;
		end else if (enter_normal) begin
			half_q <= 1'b0;
		end else if (sample_end && mode_q == `SEVT_MODE_NORMAL) begin
			half_q <= ~half_q;
		end
	end

	// ****************************************
	// register read back
	// ****************************************
	logic [15:0] rd_mux;

	always_comb begin
		unique case (rd_addr_q)
			`SEVT_OFS_STATUS:    rd_mux = {9'h000, status_q, 5'h00};
			`SEVT_OFS_MASK:      rd_mux = mask_q;
			`SEVT_OFS_PIN_CFG:   rd_mux = pin_cfg_q;
			`SEVT_OFS_RATIO:     rd_mux = {4'h0, ratio_res_q};
			`SEVT_OFS_PIN_SEL:   rd_mux = pin_sel_q;
			`SEVT_OFS_MODE:      rd_mux = {14'h0000, mode_q};
			`SEVT_OFS_SLOW_CTL:  rd_mux = slow_ctl_q;
			`SEVT_OFS_FAST_TRIM: rd_mux = fast_trim_q;
			`SEVT_OFS_CAL_CTL:   rd_mux = {10'h000, ratio_en_q, 5'h00};
			`SEVT_OFS_HOLD:      rd_mux = {13'h0000, hold_q};
			default:             rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= 16'h0000;
		end else if (rd_evt) begin
			rd_data_q <= rd_mux;
		end
	end

	// ****************************************
	// aux pin selection and drive
	// ****************************************
	sevt_pin_src_type src;

	assign src = '{irq: irq, window: window_q, led_a: slot_a_evt.led, led_b: slot_b_evt.led,
		dcyc_a: dcyc_a_q, dcyc_b: dcyc_b_q, half: half_q, osc: osc_sync_q[2]};

	function automatic logic pin_pick(input logic [4:0] code, input sevt_pin_src_type s);
		unique case (code)
			SEVT_SEL_IRQ:    return s.irq;
			SEVT_SEL_WINDOW: return s.window;
			SEVT_SEL_LED_A:  return s.led_a;
			SEVT_SEL_LED_B:  return s.led_b;
			SEVT_SEL_LED_AB: return s.led_a | s.led_b;
			SEVT_SEL_DCYC_A: return s.dcyc_a;
			SEVT_SEL_DCYC_B: return s.dcyc_b;
			SEVT_SEL_DCYC_E: return s.dcyc_a | s.dcyc_b;
			SEVT_SEL_HALF:   return s.half;
			SEVT_SEL_LOW:    return 1'b0;
			SEVT_SEL_HIGH:   return 1'b1;
			SEVT_SEL_OSC:    return s.osc;
			default:         return 1'b0;
		endcase
	endfunction

	logic [1:0] pin_o_q;
	logic [1:0] pin_oe_q;

	for (genvar g = 0; g < 2; g++) begin : g_pin
		logic [4:0] code;
		logic [2:0] cfg;
		logic       lvl;

		assign code = pin_sel_q[g*8 +: 5];
		assign cfg  = pin_cfg_q[g*`SEVT_PIN1_CFG_BASE +: 3];
		assign lvl  = pin_pick(code, src) ^ cfg[`SEVT_BIT_INV];

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				pin_o_q[g]  <= 1'b0;
				pin_oe_q[g] <= 1'b0;
			end else begin
				pin_o_q[g]  <= cfg[`SEVT_BIT_OD] ? 1'b0 : lvl;
				pin_oe_q[g] <= cfg[`SEVT_BIT_DRV] & (cfg[`SEVT_BIT_OD] ? ~lvl : 1'b1);
			end
		end
	end

	assign aux_pin_o  = pin_o_q;
	assign aux_pin_oe = pin_oe_q;

endmodule

// *** core/sevt_map.svh ***
`ifndef SEVT_MAP_SVH
`define SEVT_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define SEVT_OFS_STATUS    7'h00
`define SEVT_OFS_MASK      7'h01
`define SEVT_OFS_PIN_CFG   7'h02
`define SEVT_OFS_RATIO     7'h0a
`define SEVT_OFS_PIN_SEL   7'h0b
`define SEVT_OFS_MODE      7'h10
`define SEVT_OFS_SLOW_CTL  7'h4b
`define SEVT_OFS_FAST_TRIM 7'h4d
`define SEVT_OFS_CAL_CTL   7'h50
`define SEVT_OFS_HOLD      7'h5f

// ****************************************
// field positions
// ****************************************
`define SEVT_BIT_SLOT_A     5
`define SEVT_BIT_SLOT_B     6
`define SEVT_BIT_RATIO_EN   5
`define SEVT_BIT_CLK_ON     7
`define SEVT_BIT_CAL_MARK   0
`define SEVT_BIT_FREEZE_A   1
`define SEVT_BIT_FREEZE_B   2
`define SEVT_BIT_INV        0
`define SEVT_BIT_OD         1
`define SEVT_BIT_DRV        2
`define SEVT_PIN1_CFG_BASE  8

// ****************************************
// reset values and constants
// ****************************************
`define SEVT_RST_MASK       16'h00ff
`define SEVT_RST_PIN_CFG    16'h0004
`define SEVT_RST_PIN_SEL    16'h0000
`define SEVT_RST_SLOW_CTL   16'h0020
`define SEVT_RST_FAST_TRIM  16'h0080
`define SEVT_PIN_SEL_MASK   16'h1f1f
`define SEVT_PIN_CFG_MASK   16'h0707
`define SEVT_RATIO_NOMINAL  12'h07d0
`define SEVT_RATIO_MAX      12'hfff
`define SEVT_MODE_NORMAL    2'h2

// ****************************************
// serial port framing, in bit counts
// ****************************************
`define SEVT_CMD_LAST_BIT   6'h07
`define SEVT_WR_LAST_BIT    6'h17
`define SEVT_RD_LOAD_BIT    6'h1f
`define SEVT_BIT_CNT_MAX    6'h3f

`endif

// *** core/sevt_pkg.sv ***
package sevt_pkg;

	// ****************************************
	// selector codes for the aux pins
	// ****************************************
	typedef enum logic [4:0] {
		SEVT_SEL_IRQ    = 5'h01,
		SEVT_SEL_WINDOW = 5'h02,
		SEVT_SEL_LED_A  = 5'h05,
		SEVT_SEL_LED_B  = 5'h06,
		SEVT_SEL_LED_AB = 5'h07,
		SEVT_SEL_DCYC_A = 5'h0c,
		SEVT_SEL_DCYC_B = 5'h0d,
		SEVT_SEL_DCYC_E = 5'h0e,
		SEVT_SEL_HALF   = 5'h0f,
		SEVT_SEL_LOW    = 5'h10,
		SEVT_SEL_HIGH   = 5'h11,
		SEVT_SEL_OSC    = 5'h13
	} sevt_sel_type;

	// ****************************************
	// ratio measurement states
	// ****************************************
	typedef enum logic [3:0] {
		SEVT_RS_IDLE  = 4'b0001,
		SEVT_RS_ARM   = 4'b0010,
		SEVT_RS_COUNT = 4'b0100,
		SEVT_RS_DONE  = 4'b1000
	} sevt_ratio_state_type;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic en;
		logic start;
		logic done;
		logic led;
	} sevt_slot_evt_type;

	typedef struct packed {
		logic [6:0]  addr;
		logic [15:0] data;
	} sevt_reg_word_type;

	typedef struct packed {
		logic irq;
		logic window;
		logic led_a;
		logic led_b;
		logic dcyc_a;
		logic dcyc_b;
		logic half;
		logic osc;
	} sevt_pin_src_type;

endpackage

// *** test/sevt_monitor.sv ***
`timescale 1ns/1ps
module sevt_monitor
	import sevt_pkg::*;
(
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              rst,
	// watched ports
	input wire logic              spi_cs_n,
	input wire sevt_slot_evt_type slot_a_evt,
	input wire sevt_slot_evt_type slot_b_evt,
	input wire logic              slot_a_load,
	input wire logic              slot_b_load,
	input wire logic              sample_clock_on,
	input wire logic [5:0]        sample_clock_trim,
	input wire logic [7:0]        fast_clock_trim,
	input wire logic [1:0]        op_mode,
	input wire logic [1:0]        aux_pin_o,
	input wire logic [1:0]        aux_pin_oe
);
	// ****************
	// cycles since the last frame
	// ****************
	logic [5:0] idle_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			idle_q <= 6'h3f;
		else if (!spi_cs_n)
			idle_q <= 6'h00;
		else if (idle_q != 6'h3f)
			idle_q <= idle_q + 6'h01;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_load_a; slot_a_load |-> slot_a_evt.done && slot_a_evt.en; endproperty
	a_load_a: assert property (p_load_a) else $error("slot one load without its end");
	property p_load_b; slot_b_load |-> slot_b_evt.done && slot_b_evt.en; endproperty
	a_load_b: assert property (p_load_b) else $error("slot two load without its end");
	property p_trim_slow; $changed(sample_clock_trim) |-> idle_q < 6'h10; endproperty
	a_trim_slow: assert property (p_trim_slow) else $error("slow trim moved without a write");
	property p_trim_fast; idle_q == 6'h10 |-> $stable(fast_clock_trim) [*8]; endproperty
	a_trim_fast: assert property (p_trim_fast) else $error("fast trim moved while idle");
	property p_mode; $changed(op_mode) |-> idle_q < 6'h10; endproperty
	a_mode: assert property (p_mode) else $error("mode moved without a write");
	property p_clk_on; $rose(sample_clock_on) |-> idle_q < 6'h10; endproperty
	a_clk_on: assert property (p_clk_on) else $error("slow clock on without a write");
	property p_rst_vals;
		$fell(rst) |-> sample_clock_trim == 6'h20 && fast_clock_trim == 8'h80 && op_mode == 2'h0;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("clock fields wrong after reset");
	property p_pin_rst; $fell(rst) |-> ##2 aux_pin_oe == 2'b01 && !aux_pin_o[0]; endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pins not inactive after reset");
	c_load_a: cover property (slot_a_load);
	c_load_b: cover property (slot_b_load);
	c_mode: cover property ($changed(op_mode));
endmodule

// *** test/sevt_host_model.sv ***
`timescale 1ns/1ps
module sevt_host_model (
	// serial port
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input  wire logic spi_miso_o,
	input  wire logic spi_miso_oe
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// one access per frame, clock only inside the frame
	task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] wd, output logic [15:0] rd);
		logic [23:0] sh;
		int n;
		sh = {a, w, wd};
		n = w ? 24 : 48;
		rd = 16'h0000;
		spi_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_mosi = (i < 24) ? sh[23 - i] : ~spi_mosi;
			#6 spi_sclk = 1'b1;
			if (i >= 32)
				rd = {rd[14:0], spi_miso_oe ? spi_miso_o : ~rd[0]};
			#6 spi_sclk = 1'b0;
		end
		#6 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#100;
	endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import sevt_pkg::*;
;
	logic              ref_clk, rst, osc_slow, fast_tick;
	wire logic         spi_sclk, spi_cs_n, spi_mosi;
	logic              spi_miso_o, spi_miso_oe, slot_a_load, slot_b_load, sample_clock_on;
	logic [5:0]        sample_clock_trim;
	logic [7:0]        fast_clock_trim;
	logic [1:0]        op_mode, aux_pin_o, aux_pin_oe;
	sevt_slot_evt_type slot_evt [2];
	int                failures = 0;
	int                comparisons = 0;

	sevt_top i_sevt_top (.ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .slot_a_evt(slot_evt[0]),
		.slot_b_evt(slot_evt[1]), .osc_slow(osc_slow), .fast_tick(fast_tick), .slot_a_load(slot_a_load),
		.slot_b_load(slot_b_load), .sample_clock_on(sample_clock_on), .sample_clock_trim(sample_clock_trim),
		.fast_clock_trim(fast_clock_trim), .op_mode(op_mode), .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe));
	sevt_host_model i_sevt_host_model (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

	// ****************
	// helpers
	// ****************
	task automatic end_of_test();
		$display("counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] x;
		i_sevt_host_model.xfer(a, 1'b1, d, x);
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] d;
		i_sevt_host_model.xfer(a, 1'b0, 16'h0000, d);
		chk(exp, d);
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// one start or end pulse of a slot, returns the load seen meanwhile
	task automatic ev(input int k, input logic s, output logic ld);
		@(posedge ref_clk);
		if (s)
			slot_evt[k].start <= 1'b1;
		else
			slot_evt[k].done <= 1'b1;
		#1 ld = k ? slot_b_load : slot_a_load;
		@(posedge ref_clk);
		slot_evt[k].start <= 1'b0;
		slot_evt[k].done <= 1'b0;
	endtask
	function automatic logic lvl(input logic [4:0] c, input logic la, input logic lb, input logic os,
		input logic [1:0] dc);
		case (c)
			5'h05: return la;
			5'h0c: return dc[0];
			5'h0d: return dc[1];
			5'h0e: return dc[0] | dc[1];
			5'h06: return lb;
			5'h07: return la | lb;
			5'h11: return 1'b1;
			5'h13: return os;
			default: return 1'b0;
		endcase
	endfunction

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#2_000_000;
		failures++;
		end_of_test();
	end

	// ****************
	// tests
	// ****************
	initial begin
		logic [15:0] d, v;
		logic        la, lb, os, inv, lv, b;
		logic [3:0]  st [5];
		logic [4:0]  codes [14];
		rst = 1'b1;
		slot_evt[0] = 4'h8;
		slot_evt[1] = 4'h8;
		osc_slow = 1'b0;
		fast_tick = 1'b0;
		st = '{4'b0101, 4'b0011, 4'b1111, 4'b1010, 4'b0101};
		codes = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h03, 5'h1f};
		void'($urandom(89614));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rchk(7'h01, 16'h00ff);
		rchk(7'h02, 16'h0004);
		rchk(7'h0b, 16'h0000);
		rchk(7'h00, 16'h0000);
		rchk(7'h0a, 16'h0000);
		rchk(7'h33, 16'h0000);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			v = 16'($urandom());
			wr(7'h4b, v);
			chk({10'h000, v[5:0]}, {10'h000, sample_clock_trim});
			chk({15'h0, v[7]}, {15'h0, sample_clock_on});
			wr(7'h4d, v);
			chk({8'h00, v[7:0]}, {8'h00, fast_clock_trim});
		end
		$display("test trims done");
		wr(7'h0b, 16'h0001);
		wr(7'h01, 16'h00bf);
		ev(0, 1'b0, b);
		chk(16'h0001, {15'h0, b});
		settle();
		chk(16'h0000, {15'h0, aux_pin_o[0]});
		rchk(7'h00, 16'h0020);
		ev(1, 1'b0, b);
		settle();
		chk(16'h0001, {15'h0, aux_pin_o[0]});
		wr(7'h00, 16'h0000);
		rchk(7'h00, 16'h0060);
		wr(7'h00, 16'h0040);
		chk(16'h0000, {15'h0, aux_pin_o[0]});
		rchk(7'h00, 16'h0020);
		for (int k = 0; k < 2; k++) begin
			wr(7'h5f, 16'h0001 | (16'h0002 << k));
			ev(k, 1'b0, b);
			chk(16'h0000, {15'h0, b});
			wr(7'h5f, 16'h0001);
			ev(k, 1'b0, b);
			chk(16'h0001, {15'h0, b});
		end
		wr(7'h00, 16'h0060);
		$display("test interrupts and freeze done");
		foreach (codes[j]) begin
			inv = 1'($urandom());
			la = 1'($urandom());
			lb = 1'($urandom());
			os = 1'($urandom());
			wr(7'h02, 16'h0604 | {7'h00, inv, 7'h00, inv});
			wr(7'h0b, {3'h0, codes[j], 3'h0, codes[j]});
			slot_evt[0].led <= la;
			slot_evt[1].led <= lb;
			osc_slow <= os;
			repeat (6) @(posedge ref_clk);
			// both slots have loaded and no sample has started since, so both data-cycle flags stand
			#1 lv = lvl(codes[j], la, lb, os, 2'b11) ^ inv;
			chk({14'h0, 1'b1, lv}, {14'h0, aux_pin_oe[0], aux_pin_o[0]});
			chk({14'h0, ~lv, 1'b0}, {14'h0, aux_pin_oe[1], aux_pin_o[1]});
		end
		$display("test pin select done");
		wr(7'h02, 16'h0404);
		wr(7'h0b, 16'h0e02);
		wr(7'h10, 16'h0002);
		chk(16'h0002, {14'h0, op_mode});
		foreach (st[j]) begin
			ev(int'(st[j][3]), st[j][2], b);
			settle();
			chk({14'h0, st[j][1:0]}, {14'h0, aux_pin_o});
		end
		wr(7'h0b, 16'h000f);
		wr(7'h10, 16'h0001);
		wr(7'h10, 16'h0002);
		settle();
		chk(16'h0000, {15'h0, aux_pin_o[0]});
		for (int s = 1; s <= 2; s++) begin
			ev(0, 1'b1, b);
			ev(0, 1'b0, b);
			ev(1, 1'b1, b);
			ev(1, 1'b0, b);
			settle();
			chk({15'h0, 1'(s)}, {15'h0, aux_pin_o[0]});
		end
		$display("test timing outputs done");
		osc_slow <= 1'b0;
		for (int r = 0; r < 2; r++) begin
			wr(7'h50, 16'h0020);
			fast_tick <= 1'b1;
			repeat (4) begin
				repeat (20) @(posedge ref_clk);
				osc_slow <= 1'b1;
				repeat (20) @(posedge ref_clk);
				osc_slow <= 1'b0;
			end
			fast_tick <= 1'b0;
			i_sevt_host_model.xfer(7'h0a, 1'b0, 16'h0000, d);
			chk(16'h0001, {15'h0, (d >= 16'h004f) && (d <= 16'h0051)});
			wr(7'h50, 16'h0000);
			wr(7'h0a, 16'hffff);
			rchk(7'h0a, 16'h0000);
		end
		$display("test ratio done");
		end_of_test();
	end
endmodule

bind sevt_top sevt_monitor i_sevt_monitor (.ref_clk(ref_clk), .rst(rst), .spi_cs_n(spi_cs_n),
	.slot_a_evt(slot_a_evt), .slot_b_evt(slot_b_evt), .slot_a_load(slot_a_load), .slot_b_load(slot_b_load),
	.sample_clock_on(sample_clock_on), .sample_clock_trim(sample_clock_trim), .fast_clock_trim(fast_clock_trim),
	.op_mode(op_mode), .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe));
